// ---- hw/bkpt_cfg.svh ----
`ifndef BKPT_CFG_SVH
`define BKPT_CFG_SVH

// Register indices; byte address is base page plus four times the index
`define IDX_CTRL3      6'h29
`define IDX_A_EXT      6'h2a
`define IDX_A_HIGH     6'h2b
`define IDX_A_LOW      6'h2c
`define IDX_B_EXT      6'h2d
`define IDX_B_HIGH     6'h2e
`define IDX_B_LOW      6'h2f
`define IDX_MODE_CTRL  6'h30
`define IDX_STATUS     6'h31

// Control three fields
`define C3_A_MASK_H    7
`define C3_A_MASK_L    6
`define C3_B_MASK_H    5
`define C3_B_MASK_L    4
`define C3_A_DIR_EN    3
`define C3_A_DIR_VAL   2
`define C3_B_DIR_EN    1
`define C3_B_DIR_VAL   0

// Extended register fields
`define EXT_PAGE_LO    6

// Mode control fields
`define MC_TRACE_EN    0
`define MC_LEGACY_EN   1
`define MC_FULL        2

// Status fields
`define ST_MATCH_A     0
`define ST_MATCH_B     1
`define ST_BREAK       2
`define ST_LEGACY      3
`define ST_TRACE       4

`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000
`define AHB_OKAY       1'b0

`endif

// ---- hw/bkpt_pkg.sv ----
package bkpt_pkg;

    typedef logic [7:0] reg8_type;

    typedef enum logic [2:0] {
        op_off    = 3'b001,
        op_legacy = 3'b010,
        op_trace  = 3'b100
    } op_mode_type;

endpackage : bkpt_pkg

// ---- hw/cmp_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface cmp_if;
    import bkpt_pkg::*;
    reg8_type    ext_r;
    reg8_type    high_r;
    reg8_type    low_r;
    logic        mask_h;
    logic        mask_l;
    logic        dir_en;
    logic        dir_val;
    logic        data_mode;
    op_mode_type mode;
    logic [15:0] addr;
    logic [21:14] xaddr;
    logic [15:0] data;
    logic        rd;
    logic        valid;
    logic        flash;
    logic        match;

    modport ctl (output ext_r, high_r, low_r, mask_h, mask_l, dir_en,
                 dir_val, data_mode, mode, addr, xaddr, data, rd, valid,
                 flash, input match);
    modport unit (input ext_r, high_r, low_r, mask_h, mask_l, dir_en,
                  dir_val, data_mode, mode, addr, xaddr, data, rd, valid,
                  flash, output match);
endinterface : cmp_if

`default_nettype wire

// ---- hw/addr_comparator.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "bkpt_cfg.svh"

module addr_comparator (
    cmp_if.unit c
);
    import bkpt_pkg::*;

    function automatic logic bytes_eq(input logic [7:0] a,
                                      input logic [7:0] b);
        bytes_eq = (a == b);
    endfunction : bytes_eq

    wire       legacy   = (c.mode == op_legacy);
    wire       trace    = (c.mode == op_trace);
    // Upper page-select bit is not looked at
    wire       page_sel = c.ext_r[`EXT_PAGE_LO];
    wire       paged    = legacy ? c.flash : page_sel;
    // Only six page index bits reach the compare
    wire [5:0] ext_bus  = legacy ? c.xaddr[19:14]
                                 : c.xaddr[21:16];
    wire       ext_eq   = (c.ext_r[5:0] == ext_bus);
    wire [7:0] high_bus = (legacy && paged) ?
                              {c.high_r[7:6], c.addr[13:8]} :
                          (trace && paged) ?
                              {c.xaddr[15:14], c.addr[13:8]} :
                              c.addr[15:8];
    wire       high_eq  = bytes_eq(c.high_r, high_bus);
    wire       low_eq   = bytes_eq(c.low_r, c.addr[7:0]);
    // 1:0 falls back to a full compare
    wire       part_eq  = !c.mask_l ? (high_eq && low_eq) :
                          !c.mask_h ? high_eq : 1'b1;
    wire       addr_ok  = (!paged || ext_eq) && part_eq;
    // Data compare never looks at the extended register
    wire       data_ok  = (c.mask_h || bytes_eq(c.high_r, c.data[15:8]))
                       && (c.mask_l || bytes_eq(c.low_r, c.data[7:0]));
    wire       dir_ok   = !c.dir_en || (c.dir_val == c.rd);

    assign c.match = c.valid && !(c.mode == op_off) && dir_ok
                     && (c.data_mode ? data_ok : addr_ok);

endmodule : addr_comparator

`default_nettype wire

// ---- hw/breakpoint_address_comparators.sv ----
// Notes on behaviour
// - B direction enable off: direction ignored
// - B direction value: 0 write, 1 read
// - Full mode ignores B direction bits
// - A masks: full, 256-byte, 16K range
// - B masks in dual mode same as A
// - Full mode B masks select data bytes
// - Full mode never uses B extended register
// - Trace mode page select 00 or 01 compare
// - Upper page-select bit ignored
// - Legacy flash access: extended plus six bits
// - Legacy non-flash: full high byte compare
// - Compare bits must equal address bits
// - At most six page bits used
// - Register base relocatable by base init
// - Legacy enable overrides trace; secure blocks trace
// - Full mode needs address and data match
`timescale 1ns/1ps
`default_nettype none

`include "bkpt_cfg.svh"

module breakpoint_address_comparators (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Chip configuration
    input  wire logic [7:0]  register_base_init,
    input  wire logic        part_secured,
    // CPU bus
    input  wire logic        cpu_cycle_valid,
    input  wire logic        cpu_read,
    input  wire logic        flash_access,
    input  wire logic [15:0] cpu_addr_bus,
    input  wire logic [21:14] cpu_extended_addr_bus,
    input  wire logic [15:0] cpu_data_bus,
    // Match results
    output var  logic        match_a,
    output var  logic        match_b,
    output var  logic        break_request,
    output var  logic        legacy_breakpoint_mode,
    output var  logic        trace_debug_mode
);
    import bkpt_pkg::*;

    // Register file
    reg8_type ctrl3_r;
    reg8_type a_ext_r;
    reg8_type a_high_r;
    reg8_type a_low_r;
    reg8_type b_ext_r;
    reg8_type b_high_r;
    reg8_type b_low_r;
    reg8_type mode_ctrl_r;

    // Bus pipeline
    logic        wr_pend_r;
    logic [5:0]  wr_idx_r;
    logic [31:0] hrdata_nxt;

    // Match pipeline
    logic        match_a_r;
    logic        match_b_r;
    logic        break_r;
    op_mode_type mode_r;

    cmp_if ca ();
    cmp_if cb ();

    // Address decode
    // Block follows the base page so software can move it
    wire       base_hit  = (haddr[15:8] == register_base_init);
    wire       upper_ok  = (haddr[31:16] == 16'h0000);
    wire       addr_ph   = hsel && hready && htrans[1];
    wire       hit       = addr_ph && base_hit && upper_ok;
    wire [5:0] idx       = haddr[7:2];
    wire       rd_take   = hit && !hwrite;
    wire       wr_take   = hit && hwrite;

    // Write strobes in the data phase
    wire       wr_ctrl3  = wr_pend_r && (wr_idx_r == `IDX_CTRL3);
    wire       wr_a_ext  = wr_pend_r && (wr_idx_r == `IDX_A_EXT);
    wire       wr_a_high = wr_pend_r && (wr_idx_r == `IDX_A_HIGH);
    wire       wr_a_low  = wr_pend_r && (wr_idx_r == `IDX_A_LOW);
    wire       wr_b_ext  = wr_pend_r && (wr_idx_r == `IDX_B_EXT);
    wire       wr_b_high = wr_pend_r && (wr_idx_r == `IDX_B_HIGH);
    wire       wr_b_low  = wr_pend_r && (wr_idx_r == `IDX_B_LOW);
    wire       wr_mode   = wr_pend_r && (wr_idx_r == `IDX_MODE_CTRL);
    wire [7:0] wr_byte   = hwdata[7:0];

    // Mode selection
    wire       legacy_en = mode_ctrl_r[`MC_LEGACY_EN];
    wire       trace_en  = mode_ctrl_r[`MC_TRACE_EN];
    wire       full_mode = mode_ctrl_r[`MC_FULL];
    // Legacy wins; a secured part never enters trace mode
    wire op_mode_type mode_nxt =
        legacy_en                     ? op_legacy :
        (trace_en && !part_secured)   ? op_trace  : op_off;

    // Status byte reflects the match flops as registered on the last enabled clock
    wire [7:0] status_byte = {3'b000,
                              mode_r == op_trace,
                              mode_r == op_legacy,
                              break_r,
                              match_b_r,
                              match_a_r};

    // Read mux, index keyed
    wire [7:0] rd_byte =
        (idx == `IDX_CTRL3)     ? ctrl3_r     :
        (idx == `IDX_A_EXT)     ? a_ext_r     :
        (idx == `IDX_A_HIGH)    ? a_high_r    :
        (idx == `IDX_A_LOW)     ? a_low_r     :
        (idx == `IDX_B_EXT)     ? b_ext_r     :
        (idx == `IDX_B_HIGH)    ? b_high_r    :
        (idx == `IDX_B_LOW)     ? b_low_r     :
        (idx == `IDX_MODE_CTRL) ? mode_ctrl_r :
        (idx == `IDX_STATUS)    ? status_byte : `RST_BYTE;

    // A write still in its data phase would be missed by the read mux
    wire       fwd       = wr_pend_r && (wr_idx_r == idx)
                           && (idx != `IDX_STATUS);
    wire [7:0] rd_final  = fwd ? wr_byte : rd_byte;

    assign hrdata_nxt = rd_take ? {24'h000000, rd_final} : `RST_WORD;

    // Comparator A hookup
    assign ca.ext_r     = a_ext_r;
    assign ca.high_r    = a_high_r;
    assign ca.low_r     = a_low_r;
    assign ca.mask_h    = ctrl3_r[`C3_A_MASK_H];
    assign ca.mask_l    = ctrl3_r[`C3_A_MASK_L];
    assign ca.dir_en    = ctrl3_r[`C3_A_DIR_EN];
    assign ca.dir_val   = ctrl3_r[`C3_A_DIR_VAL];
    assign ca.data_mode = 1'b0;
    assign ca.mode      = mode_nxt;
    assign ca.addr      = cpu_addr_bus;
    assign ca.xaddr     = cpu_extended_addr_bus;
    assign ca.data      = cpu_data_bus;
    assign ca.rd        = cpu_read;
    assign ca.valid     = cpu_cycle_valid;
    assign ca.flash     = flash_access;

    // Comparator B hookup
    assign cb.ext_r     = b_ext_r;
    assign cb.high_r    = b_high_r;
    assign cb.low_r     = b_low_r;
    assign cb.mask_h    = ctrl3_r[`C3_B_MASK_H];
    assign cb.mask_l    = ctrl3_r[`C3_B_MASK_L];
    // Direction bits of B are dropped in full mode
    assign cb.dir_en    = ctrl3_r[`C3_B_DIR_EN] && !full_mode;
    assign cb.dir_val   = ctrl3_r[`C3_B_DIR_VAL];
    assign cb.data_mode = full_mode;
    assign cb.mode      = mode_nxt;
    assign cb.addr      = cpu_addr_bus;
    assign cb.xaddr     = cpu_extended_addr_bus;
    assign cb.data      = cpu_data_bus;
    assign cb.rd        = cpu_read;
    assign cb.valid     = cpu_cycle_valid;
    assign cb.flash     = flash_access;

    addr_comparator u_cmp_a (
        .c (ca.unit)
    );

    addr_comparator u_cmp_b (
        .c (cb.unit)
    );

    // Full mode demands both; dual mode either comparator
    wire break_nxt = full_mode ? (ca.match && cb.match)
                               : (ca.match || cb.match);

    // Bus slave pipeline
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 6'h00;
            hrdata    <= `RST_WORD;
            hreadyout <= 1'b1;
            hresp     <= `AHB_OKAY;
        end else if (clk_en) begin
            wr_pend_r <= wr_take;
            wr_idx_r  <= idx;
            hrdata    <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= `AHB_OKAY;
        end
    end

    // Comparator A registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_ext_r  <= `RST_BYTE;
            a_high_r <= `RST_BYTE;
            a_low_r  <= `RST_BYTE;
        end else if (clk_en) begin
            if (wr_a_ext) begin
                a_ext_r <= wr_byte;
            end
            if (wr_a_high) begin
                a_high_r <= wr_byte;
            end
            if (wr_a_low) begin
                a_low_r <= wr_byte;
            end
        end
    end

    // Comparator B registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_ext_r  <= `RST_BYTE;
            b_high_r <= `RST_BYTE;
            b_low_r  <= `RST_BYTE;
        end else if (clk_en) begin
            if (wr_b_ext) begin
                b_ext_r <= wr_byte;
            end
            if (wr_b_high) begin
                b_high_r <= wr_byte;
            end
            if (wr_b_low) begin
                b_low_r <= wr_byte;
            end
        end
    end

    // Control registers
    // Page select resets to 00, which legacy use expects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl3_r     <= `RST_BYTE;
            mode_ctrl_r <= `RST_BYTE;
        end else if (clk_en) begin
            if (wr_ctrl3) begin
                ctrl3_r <= wr_byte;
            end
            if (wr_mode) begin
                mode_ctrl_r <= wr_byte;
            end
        end
    end

    // Match results, registered on every enabled clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
            break_r   <= 1'b0;
            mode_r    <= op_off;
        end else if (clk_en) begin
            match_a_r <= ca.match;
            match_b_r <= cb.match;
            break_r   <= break_nxt;
            mode_r    <= mode_nxt;
        end
    end

    assign match_a                = match_a_r;
    assign match_b                = match_b_r;
    assign break_request          = break_r;
    assign legacy_breakpoint_mode = (mode_r == op_legacy);
    assign trace_debug_mode       = (mode_r == op_trace);

    // Unused: only whole-word single transfers are expected
    wire unused_ok = &{1'b0, hsize};

endmodule : breakpoint_address_comparators

`default_nettype wire

// ---- verif/bkpt_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module bkpt_monitor (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  register_base_init,
    // CPU side and results
    input wire logic        part_secured,
    input wire logic        cpu_cycle_valid,
    input wire logic        match_a,
    input wire logic        match_b,
    input wire logic        break_request,
    input wire logic        legacy_breakpoint_mode,
    input wire logic        trace_debug_mode
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_read_hit: assert property ((hrdata != 32'h0) && $past(clk_en) |->
        $past(hsel && hready && htrans[1] && !hwrite &&
        haddr[31:16] == 16'h0 && haddr[15:8] == register_base_init))
        else $error("read data outside a mapped read");
    a_cause_a: assert property (match_a && $past(clk_en) |->
        $past(cpu_cycle_valid))
        else $error("comparator A matched without a bus cycle");
    a_cause_b: assert property (match_b && $past(clk_en) |->
        $past(cpu_cycle_valid))
        else $error("comparator B matched without a bus cycle");
    a_break_src: assert property (break_request |-> match_a || match_b)
        else $error("break without any comparator match");
    a_mode_excl: assert property (!(legacy_breakpoint_mode && trace_debug_mode))
        else $error("both modes active at once");
    a_secure_trace: assert property ($past(part_secured) && $past(clk_en) |->
        !trace_debug_mode)
        else $error("trace mode while secured");
    a_freeze: assert property (!$past(clk_en) && $past(hresetn) |->
        $stable(match_a) && $stable(break_request))
        else $error("match changed while clock enable low");
endmodule : bkpt_monitor

bind breakpoint_address_comparators bkpt_monitor bkpt_monitor_i (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .register_base_init, .part_secured,
    .cpu_cycle_valid, .match_a, .match_b, .break_request,
    .legacy_breakpoint_mode, .trace_debug_mode);

`default_nettype wire

// ---- verif/cpu_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_model (
    // Clock
    input  wire logic         hclk,
    // CPU buses
    output var  logic         cpu_cycle_valid,
    output var  logic         cpu_read,
    output var  logic         flash_access,
    output var  logic [15:0]  cpu_addr_bus,
    output var  logic [21:14] cpu_extended_addr_bus,
    output var  logic [15:0]  cpu_data_bus
);
    initial begin
        cpu_cycle_valid = 1'b0;
        cpu_read = 1'b0;
        flash_access = 1'b0;
        cpu_addr_bus = 16'h0;
        cpu_extended_addr_bus = 8'h0;
        cpu_data_bus = 16'h0;
    end

    task automatic cycle(input logic r, f, input logic [15:0] a,
                         input logic [21:14] x, input logic [15:0] d);
        @(posedge hclk);
        cpu_cycle_valid <= 1'b1;
        cpu_read <= r;
        flash_access <= f;
        cpu_addr_bus <= a;
        cpu_extended_addr_bus <= x;
        cpu_data_bus <= d;
        @(posedge hclk);
        // Inverted idle values so a stale bus cannot fake a match
        cpu_cycle_valid <= 1'b0;
        cpu_read <= ~r;
        flash_access <= ~f;
        cpu_addr_bus <= ~a;
        cpu_extended_addr_bus <= ~x;
        cpu_data_bus <= ~d;
    endtask : cycle
endmodule : cpu_bus_model

`default_nettype wire

// ---- verif/breakpoint_address_comparators_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "bkpt_cfg.svh"

module breakpoint_address_comparators_tb;
    logic         hclk, hresetn, clk_en, hsel, hwrite, hready, hresp;
    logic         hreadyout, part_secured, cpu_cycle_valid, cpu_read;
    logic         flash_access, match_a, match_b, break_request;
    logic         legacy_breakpoint_mode, trace_debug_mode;
    logic [1:0]   htrans;
    logic [7:0]   register_base_init, pg;
    logic [15:0]  cpu_addr_bus, cpu_data_bus;
    logic [21:14] cpu_extended_addr_bus;
    logic [31:0]  haddr, hwdata, hrdata, rd_d;
    int           errors, tests_run;

    assign hready = hreadyout;

    breakpoint_address_comparators breakpoint_address_comparators_i (
        .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .register_base_init, .part_secured, .cpu_cycle_valid, .cpu_read,
        .flash_access, .cpu_addr_bus, .cpu_extended_addr_bus, .cpu_data_bus,
        .match_a, .match_b, .break_request, .legacy_breakpoint_mode,
        .trace_debug_mode);

    cpu_bus_model cpu_bus_model_i (
        .hclk, .cpu_cycle_valid, .cpu_read, .flash_access, .cpu_addr_bus,
        .cpu_extended_addr_bus, .cpu_data_bus);

    task automatic check(input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [5:0] i,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {16'h0, pg, i, 2'b00};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_d = hrdata;
    endtask : bus

    task automatic wr(input logic [5:0] i, input logic [7:0] v);
        bus(1'b1, i, {24'hffffff, v});
    endtask : wr

    task automatic rc(input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, i, 32'h0);
        check(rd_d, {24'h0, e});
    endtask : rc

    // Expected bits are {break, match B, match A}
    task automatic cc(input logic r, f, input logic [15:0] a,
                      input logic [21:14] x, input logic [15:0] d,
                      input logic [2:0] e);
        cpu_bus_model_i.cycle(r, f, a, x, d);
        @(posedge hclk);
        check({29'h0, break_request, match_b, match_a}, {29'h0, e});
    endtask : cc

    task automatic final_report;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        final_report();
    end

    initial begin
        {hresetn, hsel, hwrite, part_secured, htrans} = '0;
        {clk_en, haddr, hwdata, errors, tests_run} = '0;
        clk_en = 1'b1;
        register_base_init = 8'h40;
        pg = 8'h40;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 'h29; i <= 'h30; i++) rc(i[5:0], 8'h00);
        for (int i = 'h2a; i <= 'h2f; i++) begin
            wr(i[5:0], i[7:0] ^ 8'h5a);
            rc(i[5:0], i[7:0] ^ 8'h5a);
        end
        wr(6'h3f, 8'hff);
        rc(6'h3f, 8'h00);
        @(posedge hclk);
        register_base_init <= 8'h41;
        rc(`IDX_A_HIGH, 8'h00);
        pg = 8'h41;
        rc(`IDX_A_HIGH, 8'h71);
        // Legacy dual mode, page select kept at 00
        wr(`IDX_MODE_CTRL, 8'h02);
        wr(`IDX_A_EXT, 8'h05);
        wr(`IDX_A_HIGH, 8'hd2);
        wr(`IDX_A_LOW, 8'h34);
        wr(`IDX_B_EXT, 8'h3f);
        wr(`IDX_B_HIGH, 8'h56);
        wr(`IDX_B_LOW, 8'h78);
        wr(`IDX_CTRL3, 8'h00);
        check({30'h0, trace_debug_mode, legacy_breakpoint_mode}, 32'h1);
        rc(`IDX_STATUS, 8'h08);
        cc(1, 0, 16'hd234, 8'h00, 16'h0, 3'b101);
        cc(1, 0, 16'hd235, 8'h00, 16'h0, 3'b000);
        cc(1, 1, 16'h1234, 8'hc5, 16'h0, 3'b101);
        cc(1, 1, 16'h1234, 8'hc6, 16'h0, 3'b000);
        cc(1, 0, 16'h1234, 8'hc5, 16'h0, 3'b000);
        wr(`IDX_CTRL3, 8'h40);
        cc(1, 0, 16'hd2ff, 8'h00, 16'h0, 3'b101);
        wr(`IDX_CTRL3, 8'hc0);
        cc(1, 1, 16'h0000, 8'h05, 16'h0, 3'b101);
        cc(1, 1, 16'h0000, 8'h06, 16'h0, 3'b000);
        wr(`IDX_CTRL3, 8'h80);
        cc(1, 0, 16'hd2ff, 8'h00, 16'h0, 3'b000);
        wr(`IDX_CTRL3, 8'h00);
        cc(0, 0, 16'h5678, 8'h00, 16'h0, 3'b110);
        cc(1, 0, 16'h5678, 8'h00, 16'h0, 3'b110);
        wr(`IDX_CTRL3, 8'h02);
        cc(1, 0, 16'h5678, 8'h00, 16'h0, 3'b000);
        cc(0, 0, 16'h5678, 8'h00, 16'h0, 3'b110);
        wr(`IDX_CTRL3, 8'h03);
        cc(1, 0, 16'h5678, 8'h00, 16'h0, 3'b110);
        cc(0, 0, 16'h5678, 8'h00, 16'h0, 3'b000);
        wr(`IDX_CTRL3, 8'h10);
        cc(1, 0, 16'h56ff, 8'h00, 16'h0, 3'b110);
        // Full mode: B direction bits set yet a write still qualifies
        wr(`IDX_MODE_CTRL, 8'h06);
        wr(`IDX_CTRL3, 8'h03);
        cc(0, 1, 16'hd234, 8'h05, 16'h5678, 3'b111);
        cc(0, 0, 16'hd235, 8'h00, 16'h5678, 3'b010);
        cc(0, 0, 16'hd234, 8'h00, 16'h56ff, 3'b001);
        wr(`IDX_CTRL3, 8'h13);
        cc(0, 0, 16'hd234, 8'h00, 16'h56ff, 3'b111);
        wr(`IDX_CTRL3, 8'h23);
        cc(0, 0, 16'hd234, 8'h00, 16'hff78, 3'b111);
        wr(`IDX_CTRL3, 8'h33);
        cc(0, 0, 16'hd234, 8'h00, 16'h0000, 3'b111);
        wr(`IDX_MODE_CTRL, 8'h01);
        wr(`IDX_CTRL3, 8'h00);
        cc(1, 1, 16'hd234, 8'hff, 16'h0, 3'b101);
        wr(`IDX_A_EXT, 8'h6a);
        cc(1, 0, 16'h1234, 8'hab, 16'h0, 3'b101);
        cc(1, 0, 16'hd234, 8'haa, 16'h0, 3'b000);
        wr(`IDX_A_EXT, 8'hea);
        cc(1, 0, 16'h1234, 8'hab, 16'h0, 3'b101);
        wr(`IDX_A_EXT, 8'h85);
        cc(1, 0, 16'hd234, 8'h00, 16'h0, 3'b101);
        check({30'h0, trace_debug_mode, legacy_breakpoint_mode}, 32'h2);
        part_secured <= 1'b1;
        repeat (2) @(posedge hclk);
        check({31'h0, trace_debug_mode}, 32'h0);
        cc(1, 0, 16'hd234, 8'h00, 16'h0, 3'b000);
        part_secured <= 1'b0;
        wr(`IDX_MODE_CTRL, 8'h03);
        repeat (2) @(posedge hclk);
        check({30'h0, trace_debug_mode, legacy_breakpoint_mode}, 32'h1);
        // Frozen flops must hold the old, non-matching result
        clk_en <= 1'b0;
        cc(1, 0, 16'hd234, 8'h00, 16'h0, 3'b000);
        clk_en <= 1'b1;
        cc(1, 0, 16'hd234, 8'h00, 16'h0, 3'b101);
        final_report();
    end
endmodule : breakpoint_address_comparators_tb

`default_nettype wire
